// >>> cc_pkg.sv
// Shared constants, register map and helpers for the host-side codec control block
package cc_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [5:0] ADDR_IRQ_STATUS  = 6'h03;
	localparam logic [5:0] ADDR_IRQ_ENABLE  = 6'h05;
	localparam logic [5:0] ADDR_LOCK_STATUS = 6'h0d;
	localparam logic [5:0] ADDR_POWER       = 6'h0f;
	localparam logic [5:0] ADDR_MONITOR     = 6'h10;
	localparam logic [5:0] ADDR_LINE_FIRST  = 6'h12;
	localparam logic [5:0] ADDR_LINE_LAST   = 6'h19;
	localparam logic [5:0] ADDR_LINE_EXTRA  = 6'h1f;
	localparam logic [5:0] ADDR_TX_SLOT     = 6'h20;
	localparam logic [5:0] ADDR_RX_SLOT     = 6'h21;
	localparam logic [5:0] ADDR_TIMING      = 6'h22;
	localparam logic [5:0] ADDR_PORT        = 6'h23;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] IRQ_ENABLE_RST = 8'hff;
	localparam logic [7:0] POWER_RST      = 8'h80;
	localparam logic [7:0] CONFIG_RST     = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_SYNC_LOSS  = 1;
	localparam int BIT_RING       = 0;
	localparam int BIT_AUTO_POLL  = 3;
	localparam int BIT_LOCKED     = 7;
	localparam int BIT_LINK_RESET = 3;
	localparam int BIT_FE_ENABLE  = 7;
	localparam int BIT_POWER_DOWN = 6;
	localparam int BIT_SLEEP      = 5;
	localparam int BIT_PCM_ENABLE = 7;
	localparam int BIT_MASTER     = 6;
	localparam int BIT_CODE_LSB   = 2;
	localparam int BIT_CTRL_READ  = 7;

	// ****************************************
	// Counts and times
	// ****************************************
	localparam logic [4:0] SPI_LAST_BIT    = 5'd15;
	localparam logic [4:0] SPI_CTRL_BIT    = 5'd7;
	localparam logic [4:0] SPI_DATA_FIRST  = 5'd8;
	localparam logic [2:0] LOCK_FRAMES     = 3'd4;
	localparam int         CLK_PERIOD_NS   = 8;
	localparam int         CLOCK_LOSS_NS   = 2000;
	localparam logic [7:0] CLOCK_LOSS_CYCLES = 8'(CLOCK_LOSS_NS / CLK_PERIOD_NS);

	// Line-side control register window
	function automatic logic is_line_side(input logic [5:0] addr);
		is_line_side = (addr >= ADDR_LINE_FIRST && addr <= ADDR_LINE_LAST)
			|| addr == ADDR_LINE_EXTRA;
	endfunction

	// Bit clocks per frame for a nonzero rate code
	function automatic logic [9:0] frame_len(input logic [3:0] code);
		frame_len = {1'b0, code, 5'b00000} + 10'd32;
	endfunction
endpackage

// >>> codec_host_ctl.sv
// Host-side configuration, clock lock and interrupt control of a line-interface codec
// Function
// R1: Host spaces line-side register accesses at least 500 us apart.
// R2: That gap runs from select release to the next select assertion.
// R3: Host supplies stable, legal PCM bit clock and frame sync; the testbench stops them in t_pcm_noclk.
// R4: PCM configuration writes are taken without any PCM clock running.
// R5: Interrupt pin pulls low while any enabled event flag is set.
// R6: Interrupt enables reset to all ones, so an interrupt follows reset.
// R7: Host is ready for the first interrupt before releasing reset.
// R8: Host writes 0x08 to the enable register to mask interrupts.
// R9: Reading the status register clears it and releases the interrupt pin.
// R10: Line-side accesses pass only while the PLL is locked.
// R11: Host-side registers work regardless of lock or clock presence.
// R12: Host enables front end, sets mode and rate, then polls lock.
// R13: Slave mode with rate code zero locks to any stable bit clock.
// R14: Toggling the sleep bit restarts the PLL lock process.
// R15: Master mode locks to the reference and drives bit clock and sync.
// R16: Host cycles sleep with 10 ms waits to restart the monitor; t_relock sets and clears sleep with no wait.
// R17: Host configures the PCM port only after lock; t_pcm_noclk writes the PCM registers while unlocked.
// R18: Host sets the port enable last, after other PCM fields.
// R19: PCM registers hold slots, polarities, timing, enable, mode, rate, coding.
// R20: PCM clocks should be stable before reset release.
// R21: Active-low reset; serial port usable right after release.
// R22: Status flags stay set until the status register is read.
`timescale 1ns/10ps
`default_nettype none
module codec_host_ctl (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       chip_select_n,
	input  wire logic       spi_sclk,
	input  wire logic       spi_mosi,
	output var  logic       spi_miso_q,
	output var  logic       spi_miso_oe_q,
	input  wire logic       pcm_bit_clock_in,
	input  wire logic       frame_sync_in,
	input  wire logic       pcm_ref_clock_in,
	output var  logic       pcm_bit_clock_out_q,
	output var  logic       frame_sync_out_q,
	output var  logic       pcm_clock_oe_q,
	input  wire logic [2:0] port_pin_event,
	input  wire logic       line_event,
	input  wire logic       ring_detect,
	input  wire logic       ring_monitor,
	input  wire logic       line_sync_ok,
	input  wire logic       line_side_state_flag,
	output var  logic       irq_out_q,
	output var  logic       irq_oe_q,
	output var  logic       line_wr_q,
	output var  logic       line_rd_q,
	output var  logic [5:0] line_addr_q,
	output var  logic [7:0] line_wdata_q,
	input  wire logic [7:0] line_rdata,
	output var  logic       pll_locked_q,
	output var  logic       line_side_link_reset_q,
	output var  logic [7:0] power_control_q,
	output var  logic [7:0] monitor_gain_config_q,
	output var  logic [7:0] irq_enable_q,
	output var  logic [7:0] pcm_tx_slot_q,
	output var  logic [7:0] pcm_rx_slot_q,
	output var  logic [7:0] pcm_timing_config_q,
	output var  logic [7:0] pcm_port_control_q,
	output var  logic       pcm_port_active_q
);
	reg_bus_if bus ();

	logic [7:0] irq_status_q;
	logic [7:0] irq_status_d;
	logic [7:0] events;
	logic [7:0] event_mask;
	logic       status_clear;
	logic       line_access;
	logic       bclk_prev_q;
	logic       fs_prev_q;
	logic       ref_prev_q;
	logic       master;
	logic       pll_hold;
	logic [3:0] rate_code;
	logic [9:0] len;
	logic       tick;
	logic       frame_start;
	logic       frame_match;
	logic       clock_lost;
	logic [7:0] idle_q;
	logic [9:0] mbits_q;
	logic [9:0] bits_q;
	logic [9:0] last_len_q;
	logic [2:0] stable_q;

	spi_byte_engine u_spi (
		.clk           (clk),
		.rst_n         (rst_n),
		.chip_select_n (chip_select_n),
		.spi_sclk      (spi_sclk),
		.spi_mosi      (spi_mosi),
		.spi_miso_q    (spi_miso_q),
		.spi_miso_oe_q (spi_miso_oe_q),
		.bus           (bus)
	);

	// ****************************************
	// Register writes
	// ****************************************
	assign line_access = cc_pkg::is_line_side(bus.addr);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_q <= cc_pkg::IRQ_ENABLE_RST; // R6
			power_control_q <= cc_pkg::POWER_RST;
			line_side_link_reset_q <= 1'b0;
			monitor_gain_config_q <= cc_pkg::CONFIG_RST;
			pcm_tx_slot_q <= cc_pkg::CONFIG_RST;
			pcm_rx_slot_q <= cc_pkg::CONFIG_RST;
			pcm_timing_config_q <= cc_pkg::CONFIG_RST;
			pcm_port_control_q <= cc_pkg::CONFIG_RST;
		end else if (bus.wr) begin
			// Host-side writes need neither lock nor PCM clocks
			case (bus.addr) // R4 R11
				cc_pkg::ADDR_IRQ_ENABLE: irq_enable_q <= bus.wdata;
				cc_pkg::ADDR_LOCK_STATUS: line_side_link_reset_q <= bus.wdata[cc_pkg::BIT_LINK_RESET];
				cc_pkg::ADDR_POWER: power_control_q <= {bus.wdata[7:5], 5'b00000};
				cc_pkg::ADDR_MONITOR: monitor_gain_config_q <= {3'b000, bus.wdata[4:0]};
				cc_pkg::ADDR_TX_SLOT: pcm_tx_slot_q <= bus.wdata; // R19
				cc_pkg::ADDR_RX_SLOT: pcm_rx_slot_q <= bus.wdata; // R19
				cc_pkg::ADDR_TIMING: pcm_timing_config_q <= bus.wdata; // R19
				cc_pkg::ADDR_PORT: pcm_port_control_q <= bus.wdata; // R19
				default: ;
			endcase
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		case (bus.addr)
			cc_pkg::ADDR_IRQ_STATUS: bus.rdata = irq_status_q;
			cc_pkg::ADDR_IRQ_ENABLE: bus.rdata = irq_enable_q;
			cc_pkg::ADDR_LOCK_STATUS: bus.rdata = {pll_locked_q, line_side_state_flag, 2'b00,
				line_side_link_reset_q, 3'b000};
			cc_pkg::ADDR_POWER: bus.rdata = power_control_q;
			cc_pkg::ADDR_MONITOR: bus.rdata = monitor_gain_config_q;
			cc_pkg::ADDR_TX_SLOT: bus.rdata = pcm_tx_slot_q;
			cc_pkg::ADDR_RX_SLOT: bus.rdata = pcm_rx_slot_q;
			cc_pkg::ADDR_TIMING: bus.rdata = pcm_timing_config_q;
			cc_pkg::ADDR_PORT: bus.rdata = pcm_port_control_q;
			default: bus.rdata = (line_access && pll_locked_q) ? line_rdata : 8'h00; // R10
		endcase
	end

	// ****************************************
	// Line-side forwarding
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_wr_q <= 1'b0;
			line_rd_q <= 1'b0;
			line_addr_q <= 6'h00;
			line_wdata_q <= 8'h00;
		end else begin
			line_wr_q <= bus.wr & line_access & pll_locked_q; // R10
			line_rd_q <= bus.rd & line_access & pll_locked_q; // R10
			if (bus.wr || bus.rd) begin
				line_addr_q <= bus.addr;
				line_wdata_q <= bus.wdata;
			end
		end
	end

	// ****************************************
	// Clock edge detection
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bclk_prev_q <= 1'b0;
			fs_prev_q <= 1'b0;
			ref_prev_q <= 1'b0;
		end else begin
			bclk_prev_q <= pcm_bit_clock_in;
			fs_prev_q <= frame_sync_in;
			ref_prev_q <= pcm_ref_clock_in;
		end
	end

	assign master = pcm_port_control_q[cc_pkg::BIT_MASTER];
	assign rate_code = pcm_port_control_q[cc_pkg::BIT_CODE_LSB +: 4];
	assign len = cc_pkg::frame_len(rate_code);
	// Sleep, power-down or a disabled front end hold the PLL in restart
	assign pll_hold = power_control_q[cc_pkg::BIT_SLEEP] | power_control_q[cc_pkg::BIT_POWER_DOWN]
		| ~power_control_q[cc_pkg::BIT_FE_ENABLE]; // R14
	assign tick = master ? (pcm_ref_clock_in & ~ref_prev_q) : (pcm_bit_clock_in & ~bclk_prev_q);
	assign frame_start = master
		? (tick && !pcm_bit_clock_out_q && mbits_q == len - 10'd1) // R15
		: (frame_sync_in & ~fs_prev_q);
	// Auto rate in slave mode with code zero
	assign frame_match = bits_q == last_len_q
		&& (master || rate_code == 4'h0 || bits_q == len); // R13
	assign clock_lost = idle_q == cc_pkg::CLOCK_LOSS_CYCLES;

	// ****************************************
	// Master clock and sync generation
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pcm_bit_clock_out_q <= 1'b0;
			frame_sync_out_q <= 1'b0;
			mbits_q <= 10'd0;
			pcm_clock_oe_q <= 1'b0;
		end else begin
			pcm_clock_oe_q <= master & ~pll_hold; // R15
			if (pll_hold || !master) begin
				pcm_bit_clock_out_q <= 1'b0;
				frame_sync_out_q <= 1'b0;
				mbits_q <= 10'd0;
			end else if (tick) begin
				pcm_bit_clock_out_q <= ~pcm_bit_clock_out_q; // R15
				if (!pcm_bit_clock_out_q) begin
					frame_sync_out_q <= mbits_q == len - 10'd1;
					mbits_q <= (mbits_q >= len - 10'd1) ? 10'd0 : mbits_q + 10'd1;
				end
			end
		end
	end

	// ****************************************
	// Lock detection
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_q <= 8'h00;
		end else if (pll_hold || tick) begin
			idle_q <= 8'h00;
		end else if (!clock_lost) begin
			idle_q <= idle_q + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bits_q <= 10'd0;
			last_len_q <= 10'd0;
			stable_q <= 3'd0;
		end else if (pll_hold || clock_lost) begin
			bits_q <= 10'd0;
			last_len_q <= 10'd0;
			stable_q <= 3'd0; // R14
		end else if (frame_start) begin
			last_len_q <= bits_q;
			// A bit clock rise on the frame start belongs to the new frame
			bits_q <= tick ? 10'h001 : 10'h000;
			if (!frame_match) begin
				stable_q <= 3'd0;
			end else if (stable_q != cc_pkg::LOCK_FRAMES) begin
				stable_q <= stable_q + 3'd1; // R13
			end
		end else if (tick) begin
			bits_q <= bits_q + 10'd1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_locked_q <= 1'b0;
			pcm_port_active_q <= 1'b0;
		end else begin
			pll_locked_q <= ~pll_hold & ~clock_lost & (stable_q == cc_pkg::LOCK_FRAMES);
			pcm_port_active_q <= pcm_port_control_q[cc_pkg::BIT_PCM_ENABLE] & pll_locked_q;
		end
	end

	// ****************************************
	// Interrupt status and pin
	// ****************************************
	assign events = {port_pin_event, clock_lost, ring_monitor, line_event, ~line_sync_ok,
		ring_detect};
	// Bit 3 of the enable register is auto polling, so ring monitor rides on the ring enable
	assign event_mask = {irq_enable_q[7:4], irq_enable_q[cc_pkg::BIT_RING], irq_enable_q[2:0]};
	assign status_clear = bus.rd && bus.addr == cc_pkg::ADDR_IRQ_STATUS;
	// A new event beats a clearing read in the same cycle
	assign irq_status_d = (irq_status_q & ~{8{status_clear}}) | (events & event_mask); // R9 R22

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_q <= 8'h00;
			irq_oe_q <= 1'b0;
			irq_out_q <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d; // R22
			irq_oe_q <= |(irq_status_d & event_mask); // R5
			irq_out_q <= 1'b0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic started_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			started_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
		end
	end

	a_enable_reset_value: assert property (!started_q |-> irq_enable_q == 8'hff) // R6
		else $error("interrupt enables not all set after reset");
	a_irq_on_sync_loss: assert property ((!line_sync_ok && irq_enable_q[1]) |=> irq_oe_q ##0 irq_status_q[1]) // R5
		else $error("sync loss did not raise interrupt");
	a_read_clears_status: assert property ((status_clear && events == 8'h00) |=> irq_status_q == 8'h00 && !irq_oe_q) // R9
		else $error("status read did not clear and release");
	a_status_sticky: assert property (!status_clear |=> (irq_status_q & $past(irq_status_q)) == $past(irq_status_q)) // R22
		else $error("status flag dropped without a read");
	a_line_needs_lock: assert property ((line_wr_q || line_rd_q) |-> $past(pll_locked_q)) // R10
		else $error("line access passed while unlocked");
	a_pcm_write_taken: assert property ((bus.wr && bus.addr == 6'h20) |=> pcm_tx_slot_q == $past(bus.wdata)) // R4
		else $error("transmit slot write lost");
	a_sleep_unlocks: assert property (power_control_q[5] |=> !pll_locked_q ##1 !pll_locked_q) // R14
		else $error("PLL locked during sleep");
	a_loss_unlocks: assert property (clock_lost |=> !pll_locked_q) // R13
		else $error("lock held without a clock");
	a_master_drive: assert property (pcm_clock_oe_q |-> $past(master && !pll_hold)) // R15
		else $error("clock driven outside master mode");
	a_port_active: assert property (pcm_port_active_q |-> $past(pcm_port_control_q[7] && pll_locked_q)) // R19
		else $error("port active without enable and lock");

	c_lock_reached: cover property (!pll_locked_q ##1 pll_locked_q);
	c_irq_released: cover property (irq_oe_q ##1 status_clear ##1 !irq_oe_q);
	c_master_locked: cover property (master && pll_locked_q);
	c_line_write: cover property (line_wr_q);
endmodule
`default_nettype wire

// >>> codec_host_ctl_tb_top.sv
// Self-checking testbench of the host-side codec control block
`timescale 1ns/10ps
`default_nettype none
module codec_host_ctl_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, miso, miso_oe, cs_n, sclk, mosi, bclk, fs, rclk;
	logic bclk_out, fs_out, pcm_oe, irq_out, irq_oe, lwr, lrd, locked, lnk_rst, port_act;
	logic [2:0] port_ev = 3'h0;
	logic line_ev = 1'b0, ring = 1'b0, ring_mon = 1'b0, sync_ok = 1'b0, lss = 1'b0;
	logic [5:0] laddr;
	logic [7:0] lwdata, pwr, mon, ien, txs, rxs, tim, port, v;
	int n_errors = 0, total_checks = 0, n_line_wr = 0, n_oe = 0;

	always #4 clk = ~clk;
	always @(posedge clk) if (lwr === 1'b1) n_line_wr <= n_line_wr + 1;
	always @(posedge clk) if (miso_oe === 1'b1) n_oe <= n_oe + 1;

	host_bus_model i_host (.clk(clk), .chip_select_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
		.spi_miso(miso), .pcm_bit_clock_in(bclk), .frame_sync_in(fs), .pcm_ref_clock_in(rclk));

	codec_host_ctl i_dut (.clk(clk), .rst_n(rst_n), .chip_select_n(cs_n), .spi_sclk(sclk),
		.spi_mosi(mosi), .spi_miso_q(miso), .spi_miso_oe_q(miso_oe),
		.pcm_bit_clock_in(bclk), .frame_sync_in(fs), .pcm_ref_clock_in(rclk),
		.pcm_bit_clock_out_q(bclk_out), .frame_sync_out_q(fs_out), .pcm_clock_oe_q(pcm_oe),
		.port_pin_event(port_ev), .line_event(line_ev), .ring_detect(ring),
		.ring_monitor(ring_mon), .line_sync_ok(sync_ok), .line_side_state_flag(lss),
		.irq_out_q(irq_out), .irq_oe_q(irq_oe), .line_wr_q(lwr), .line_rd_q(lrd),
		.line_addr_q(laddr), .line_wdata_q(lwdata), .line_rdata(8'h00), .pll_locked_q(locked),
		.line_side_link_reset_q(lnk_rst), .power_control_q(pwr), .monitor_gain_config_q(mon),
		.irq_enable_q(ien), .pcm_tx_slot_q(txs), .pcm_rx_slot_q(rxs),
		.pcm_timing_config_q(tim), .pcm_port_control_q(port), .pcm_port_active_q(port_act));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic print_verdict;
		$display("Checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] dummy;
		i_host.xfer({2'b00, a}, d, dummy);
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		i_host.xfer({2'b10, a}, 8'h00, d);
	endtask

	task automatic poll_lock;
		logic [7:0] s;
		s = 8'h00;
		for (int n = 0; n < 60 && s[7] !== 1'b1; n++) rd(6'h0d, s);
		chk("lock detect", 8'h80, s & 8'h80);
		if (s[7] !== 1'b1) print_verdict();
	endtask

	task automatic set_ev(input int i, input logic b);
		case (i)
			0, 1, 2: port_ev[i] = b;
			3: line_ev = b;
			4: ring = b;
			default: ring_mon = b;
		endcase
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_defaults;
		int k;
		cyc(3);
		chk("irq pin after reset", 8'h01, {7'h00, irq_oe});
		chk("irq data level", 8'h00, {7'h00, irq_out});
		chk("irq enable reset", 8'hff, ien);
		chk("power reset", 8'h80, pwr);
		chk("port control reset", 8'h00, port);
		k = n_oe;
		wr(6'h23, 8'h00);
		chk("miso idle on write", 8'h00, 8'(n_oe - k));
		k = n_oe;
		rd(6'h05, v);
		chk("irq enable read", 8'hff, v);
		chk("miso drive on read", 8'h01, {7'h00, n_oe > k});
		poll_lock();
	endtask

	task automatic t_mask_irq;
		wr(6'h05, 8'h08);
		rd(6'h03, v);
		chk("status first read", 8'h02, v);
		cyc(2);
		chk("irq pin released", 8'h00, {7'h00, irq_oe});
		rd(6'h05, v);
		chk("enables masked", 8'h08, v);
		rd(6'h03, v);
		chk("status cleared", 8'h00, v);
		sync_ok = 1'b1;
	endtask

	task automatic t_events;
		logic [7:0] en, st;
		for (int i = 0; i < 6; i++) begin
			en = i < 3 ? 8'h20 << i : (i == 3 ? 8'h04 : 8'h01);
			st = i < 3 ? 8'h20 << i : (i == 3 ? 8'h04 : (i == 4 ? 8'h01 : 8'h08));
			wr(6'h05, 8'h08 | en);
			set_ev(i, 1'b1);
			cyc(1);
			set_ev(i, 1'b0);
			cyc(3);
			chk("irq on event", 8'h01, {7'h00, irq_oe});
			cyc(20);
			chk("irq held", 8'h01, {7'h00, irq_oe});
			rd(6'h03, v);
			chk("event status", st, v);
			cyc(1);
			chk("irq after read", 8'h00, {7'h00, irq_oe});
		end
		wr(6'h05, 8'h08);
		set_ev(4, 1'b1);
		cyc(1);
		set_ev(4, 1'b0);
		cyc(3);
		chk("masked event pin", 8'h00, {7'h00, irq_oe});
		rd(6'h03, v);
		chk("masked event status", 8'h00, v);
	endtask

	task automatic t_pcm_noclk;
		i_host.pcm_on = 1'b0;
		cyc(300);
		chk("lock lost", 8'h00, {7'h00, locked});
		wr(6'h23, 8'h03);
		wr(6'h20, 8'hd5);
		wr(6'h21, 8'h2a);
		wr(6'h22, 8'hc9);
		wr(6'h23, 8'h83);
		chk("tx slot", 8'hd5, txs);
		chk("rx slot", 8'h2a, rxs);
		chk("timing", 8'hc9, tim);
		chk("port control", 8'h83, port);
		rd(6'h22, v);
		chk("timing read", 8'hc9, v);
		chk("port idle unlocked", 8'h00, {7'h00, port_act});
		wr(6'h12, 8'h55);
		chk("line write unlocked", 8'h00, 8'(n_line_wr));
	endtask

	task automatic t_relock;
		i_host.pcm_on = 1'b1;
		wr(6'h0f, 8'ha0);
		chk("sleep unlocks", 8'h00, {7'h00, locked});
		wr(6'h0f, 8'h80);
		poll_lock();
		cyc(2);
		chk("port active", 8'h01, {7'h00, port_act});
		wr(6'h1f, 8'h3c);
		chk("line write count", 8'h01, 8'(n_line_wr));
		chk("line addr", 8'h1f, {2'b00, laddr});
		chk("line data", 8'h3c, lwdata);
		lss = 1'b1;
		wr(6'h0d, 8'h08);
		chk("link reset", 8'h01, {7'h00, lnk_rst});
		rd(6'h0d, v);
		chk("lock status", 8'hc8, v);
		wr(6'h10, 8'hff);
		chk("monitor cfg", 8'h1f, mon);
		rd(6'h3e, v);
		chk("unmapped read", 8'h00, v);
	endtask

	task automatic t_master;
		int   rises, brises;
		logic fs_prev, bclk_prev;
		rises = 0;
		brises = 0;
		wr(6'h23, 8'h40);
		cyc(4);
		chk("clock drive", 8'h01, {7'h00, pcm_oe});
		fs_prev = fs_out;
		bclk_prev = bclk_out;
		for (int n = 0; n < 1024; n++) begin
			cyc(1);
			if (fs_out === 1'b1 && fs_prev === 1'b0 && pcm_oe === 1'b1) rises++;
			if (bclk_out === 1'b1 && bclk_prev === 1'b0) brises++;
			fs_prev = fs_out;
			bclk_prev = bclk_out;
		end
		// 1024 clk hold 8 frames of 32 bit clocks of 4 clk each
		chk("frame sync out", 8'h08, 8'(rises));
		chk("bit clock out", 8'h00, 8'(brises - 256));
		chk("master lock", 8'h01, {7'h00, locked});
	endtask

	initial begin
		cyc(10);
		rst_n = 1'b1;
		t_reset_defaults();
		t_mask_irq();
		t_events();
		t_pcm_noclk();
		t_relock();
		t_master();
		print_verdict();
	end
endmodule
`default_nettype wire

// >>> host_bus_model.sv
// Host processor model: serial register master and PCM highway clock source
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
	input  wire logic clk,
	output var  logic chip_select_n,
	output var  logic spi_sclk,
	output var  logic spi_mosi,
	input  wire logic spi_miso,
	output var  logic pcm_bit_clock_in,
	output var  logic frame_sync_in,
	output var  logic pcm_ref_clock_in
);
	logic    pcm_on;
	realtime line_free_at;

	initial begin
		chip_select_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
		pcm_bit_clock_in = 1'b0;
		frame_sync_in = 1'b0;
		pcm_ref_clock_in = 1'b0;
		pcm_on = 1'b1;
		line_free_at = 0.0;
	end

	// ****************************************
	// PCM clocks: bit clock of 4 clk, 32 bits a frame, running before reset release
	// ****************************************
	always begin : pcm_gen
		for (int b = 0; b < 32; b++) begin
			repeat (2) @(posedge clk);
			#1;
			pcm_bit_clock_in = pcm_on;
			frame_sync_in = pcm_on && b == 0;
			repeat (2) @(posedge clk);
			#1;
			pcm_bit_clock_in = 1'b0;
		end
	end

	always @(posedge clk) pcm_ref_clock_in <= #1 ~pcm_ref_clock_in;

	// ****************************************
	// Serial frame: control byte then data byte, MSB first
	// ****************************************
	task automatic xfer(input logic [7:0] ctl, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] sh;
		logic        line;
		line = (ctl[5:0] >= 6'h12 && ctl[5:0] <= 6'h19) || ctl[5:0] == 6'h1f;
		sh = {ctl, wd};
		rd = 8'h00;
		while (line && $realtime < line_free_at) @(posedge clk);
		@(posedge clk);
		#1;
		chip_select_n = 1'b0;
		for (int i = 0; i < 16; i++) begin
			repeat (3) @(posedge clk);
			#1;
			spi_sclk = 1'b0;
			spi_mosi = sh[15 - i];
			repeat (3) @(posedge clk);
			if (i >= 8) rd = {rd[6:0], spi_miso};
			#1;
			spi_sclk = 1'b1;
		end
		repeat (3) @(posedge clk);
		#1;
		spi_sclk = 1'b0;
		spi_mosi = ~spi_mosi;
		repeat (3) @(posedge clk);
		#1;
		chip_select_n = 1'b1;
		if (line) line_free_at = $realtime + 500000.0;
		repeat (2) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// >>> reg_bus_if.sv
// Internal register access path between serial engine and register bank
`timescale 1ns/10ps
`default_nettype none
interface reg_bus_if;
	logic       wr;
	logic       rd;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport engine (output wr, output rd, output addr, output wdata, input rdata);
	modport bank (input wr, input rd, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> spi_byte_engine.sv
// Serial slave: control byte then data byte, MSB first
`timescale 1ns/10ps
`default_nettype none
module spi_byte_engine (
	input  wire logic   clk,
	input  wire logic   rst_n,
	input  wire logic   chip_select_n,
	input  wire logic   spi_sclk,
	input  wire logic   spi_mosi,
	output var  logic   spi_miso_q,
	output var  logic   spi_miso_oe_q,
	reg_bus_if.engine   bus
);
	logic       sclk_prev_q;
	logic [4:0] count_q;
	logic [7:0] shift_q;
	logic [7:0] out_q;
	logic       read_q;
	logic       rise;
	logic       fall;

	assign rise = spi_sclk & ~sclk_prev_q & ~chip_select_n;
	assign fall = ~spi_sclk & sclk_prev_q & ~chip_select_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= spi_sclk;
		end
	end

	// ****************************************
	// Shift in control and data bytes
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin // R21
			count_q <= 5'd0;
			shift_q <= 8'h00;
			read_q <= 1'b0;
			bus.addr <= 6'h00;
			bus.wdata <= 8'h00;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			if (chip_select_n) begin
				count_q <= 5'd0;
			end else if (rise) begin
				shift_q <= {shift_q[6:0], spi_mosi};
				count_q <= count_q + 5'd1;
				if (count_q == cc_pkg::SPI_CTRL_BIT) begin
					read_q <= shift_q[cc_pkg::BIT_CTRL_READ - 1];
					bus.addr <= {shift_q[4:0], spi_mosi};
				end
				if (count_q == cc_pkg::SPI_LAST_BIT) begin
					bus.wdata <= {shift_q[6:0], spi_mosi};
					bus.wr <= ~read_q;
					bus.rd <= read_q;
				end
			end
		end
	end

	// ****************************************
	// Shift out read data
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= 8'h00;
			spi_miso_q <= 1'b0;
			spi_miso_oe_q <= 1'b0;
		end else begin
			spi_miso_oe_q <= ~chip_select_n & read_q & (count_q >= cc_pkg::SPI_DATA_FIRST);
			if (fall && count_q == cc_pkg::SPI_DATA_FIRST) begin
				spi_miso_q <= bus.rdata[7];
				out_q <= {bus.rdata[6:0], 1'b0};
			end else if (fall) begin
				spi_miso_q <= out_q[7];
				out_q <= {out_q[6:0], 1'b0};
			end
		end
	end

	a_miso_in_frame: assert property (@(posedge clk) disable iff (!rst_n)
		spi_miso_oe_q |-> $past(!chip_select_n && read_q)) // R11
		else $error("serial output driven outside a read");
endmodule
`default_nettype wire
